//--- rtl/coeff_bank_pkg.sv
// Purpose: constants for the right channel filter coefficient bank
// Assumes: byte-wide control port, page 1 register indices
// Notes:   five coefficients, each an upper and a lower byte
package coeff_bank_pkg;

   localparam int unsigned BYTE_W    = 8;
   localparam int unsigned COEFF_W   = 16;
   localparam int unsigned INDEX_W   = 7;
   localparam int unsigned PAGE_W    = 8;
   localparam int unsigned NUM_COEFF = 5;
   localparam int unsigned SLOT_W    = 3;

   localparam logic [PAGE_W-1:0]  BANK_PAGE = 8'h01;

   // register indices on the bank page
   localparam logic [INDEX_W-1:0] RIGHT_EFFECTS_DEN4_HIGH = 7'h2B;
   localparam logic [INDEX_W-1:0] RIGHT_EFFECTS_DEN4_LOW  = 7'h2C;
   localparam logic [INDEX_W-1:0] RIGHT_EFFECTS_DEN5_HIGH = 7'h2D;
   localparam logic [INDEX_W-1:0] RIGHT_EFFECTS_DEN5_LOW  = 7'h2E;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_NUM0_HIGH  = 7'h2F;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_NUM0_LOW   = 7'h30;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_NUM1_HIGH  = 7'h31;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_NUM1_LOW   = 7'h32;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_DEN1_HIGH  = 7'h33;
   localparam logic [INDEX_W-1:0] RIGHT_DEEMPH_DEN1_LOW   = 7'h34;

   localparam logic [INDEX_W-1:0] BANK_FIRST = RIGHT_EFFECTS_DEN4_HIGH;
   localparam logic [INDEX_W-1:0] BANK_LAST  = RIGHT_DEEMPH_DEN1_LOW;

   // values after reset
   localparam logic [BYTE_W-1:0] RST_EFFECTS_DEN4_HIGH = 8'h7D;
   localparam logic [BYTE_W-1:0] RST_EFFECTS_DEN4_LOW  = 8'h83;
   localparam logic [BYTE_W-1:0] RST_EFFECTS_DEN5_HIGH = 8'h84;
   localparam logic [BYTE_W-1:0] RST_EFFECTS_DEN5_LOW  = 8'hEE;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_NUM0_HIGH  = 8'h39;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_NUM0_LOW   = 8'h55;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_NUM1_HIGH  = 8'hF3;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_NUM1_LOW   = 8'h2D;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_DEN1_HIGH  = 8'h53;
   localparam logic [BYTE_W-1:0] RST_DEEMPH_DEN1_LOW   = 8'h7E;

   // slot order: den4, den5, num0, num1, deemph den1
   localparam logic [SLOT_W-1:0] SLOT_EFFECTS_DEN4 = 3'h0;
   localparam logic [SLOT_W-1:0] SLOT_EFFECTS_DEN5 = 3'h1;
   localparam logic [SLOT_W-1:0] SLOT_DEEMPH_NUM0  = 3'h2;
   localparam logic [SLOT_W-1:0] SLOT_DEEMPH_NUM1  = 3'h3;
   localparam logic [SLOT_W-1:0] SLOT_DEEMPH_DEN1  = 3'h4;

   localparam logic [BYTE_W-1:0] RST_HIGH [NUM_COEFF] = '{
      RST_EFFECTS_DEN4_HIGH, RST_EFFECTS_DEN5_HIGH, RST_DEEMPH_NUM0_HIGH,
      RST_DEEMPH_NUM1_HIGH, RST_DEEMPH_DEN1_HIGH};
   localparam logic [BYTE_W-1:0] RST_LOW [NUM_COEFF] = '{
      RST_EFFECTS_DEN4_LOW, RST_EFFECTS_DEN5_LOW, RST_DEEMPH_NUM0_LOW,
      RST_DEEMPH_NUM1_LOW, RST_DEEMPH_DEN1_LOW};

   localparam logic [BYTE_W-1:0] READ_IDLE = 8'h00;

endpackage : coeff_bank_pkg

//--- rtl/coeff_pair.sv
// Purpose: one signed coefficient held as an upper and a lower byte
// Assumes: write strobes are one-cycle and never both for the same byte
// Notes:   both bytes are plain read/write storage
module coeff_pair
   import coeff_bank_pkg::*;
#(
   parameter logic [7:0] RESET_HIGH = 8'h00,
   parameter logic [7:0] RESET_LOW  = 8'h00
) (
   input  wire  logic               clk_sys_i,
   input  wire  logic               arst_n_i,
   input  wire  logic               wr_high_i,
   input  wire  logic               wr_low_i,
   input  wire  logic [BYTE_W-1:0]  wr_data_i,
   output logic       [BYTE_W-1:0]  high_o,
   output logic       [BYTE_W-1:0]  low_o,
   output logic signed [COEFF_W-1:0] coeff_o
);

   logic [BYTE_W-1:0] high;
   logic [BYTE_W-1:0] low;
   logic [BYTE_W-1:0] next_high;
   logic [BYTE_W-1:0] next_low;

   always_comb begin
      next_high = high;
      next_low  = low;
      if (wr_high_i) begin
         next_high = wr_data_i;
      end
      if (wr_low_i) begin
         next_low = wr_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         high <= RESET_HIGH;
         low  <= RESET_LOW;
      end else begin
         high <= next_high;
         low  <= next_low;
      end
   end

   assign high_o  = high;
   assign low_o   = low;
   // upper byte carries the sign, full signed 16-bit span
   assign coeff_o = signed'({high, low});

endmodule // coeff_pair

//--- rtl/right_filter_coeff_bank.sv
// Purpose: right channel effects and de-emphasis coefficient registers
// Assumes: control port strobes synchronous to clk_sys_i, one access per cycle
// Notes:   coefficients go to the filter datapath as signed 16-bit words;
//          read data is registered and stands until the next read

// Functional notes
// - each upper and lower byte pair forms one signed 16-bit coefficient
// - every bank register is a full 8-bit read and write field
// - effects den4 resets to upper 7D and lower 83
// - effects den5 resets to upper 84 and lower EE
// - de-emphasis num0 resets to upper 39 and lower 55
// - de-emphasis num1 resets to upper F3 and lower 2D
// - de-emphasis den1 upper byte resets to 53
// - de-emphasis den1 lower byte resets to 7E
module right_filter_coeff_bank
   import coeff_bank_pkg::*;
(
   // clock and reset
   input  wire  logic                      clk_sys_i,
   input  wire  logic                      arst_n_i,
   // control port
   input  wire  logic        [PAGE_W-1:0]  page_i,
   input  wire  logic        [INDEX_W-1:0] index_i,
   input  wire  logic                      wr_en_i,
   input  wire  logic        [BYTE_W-1:0]  wr_data_i,
   input  wire  logic                      rd_en_i,
   output logic                            hit_o,
   output logic              [BYTE_W-1:0]  rd_data_o,
   // coefficients to the filter datapath
   output logic signed       [COEFF_W-1:0] effects_den4_o,
   output logic signed       [COEFF_W-1:0] effects_den5_o,
   output logic signed       [COEFF_W-1:0] deemph_num0_o,
   output logic signed       [COEFF_W-1:0] deemph_num1_o,
   output logic signed       [COEFF_W-1:0] deemph_den1_o
);

   // byte views of every pair, indexed by slot
   logic        [BYTE_W-1:0]  high_byte [NUM_COEFF];
   logic        [BYTE_W-1:0]  low_byte  [NUM_COEFF];
   logic signed [COEFF_W-1:0] coeff     [NUM_COEFF];

   // per-byte write strobes
   logic                      wr_high   [NUM_COEFF];
   logic                      wr_low    [NUM_COEFF];

   // decoded access
   logic                      access_hit;
   logic        [SLOT_W-1:0]  access_slot;
   logic                      access_upper;

   // readback register
   logic        [BYTE_W-1:0]  rd_data;
   logic        [BYTE_W-1:0]  next_rd_data;

   // true when the page and index fall inside this bank
   function automatic logic bank_hit(input logic [PAGE_W-1:0]  page,
                                     input logic [INDEX_W-1:0] index);
      return (page == BANK_PAGE) && (index >= BANK_FIRST) && (index <= BANK_LAST);
   endfunction

   // pairs sit on consecutive indices, upper byte first
   function automatic logic [SLOT_W-1:0] slot_of(input logic [INDEX_W-1:0] index);
      logic [INDEX_W-1:0] offset;
      offset = index - BANK_FIRST;
      return offset[SLOT_W:1];
   endfunction

   function automatic logic upper_of(input logic [INDEX_W-1:0] index);
      logic [INDEX_W-1:0] offset;
      offset = index - BANK_FIRST;
      return !offset[0];
   endfunction

   // one decode shared by the write and the read paths
   always_comb begin
      access_hit   = bank_hit(page_i, index_i);
      access_slot  = slot_of(index_i);
      access_upper = upper_of(index_i);
   end

   // misses are ignored, so other pages never disturb the bank
   always_comb begin
      for (int s = 0; s < NUM_COEFF; s++) begin
         wr_high[s] = wr_en_i && access_hit && access_upper
                      && (access_slot == s[SLOT_W-1:0]);
         wr_low[s]  = wr_en_i && access_hit && !access_upper
                      && (access_slot == s[SLOT_W-1:0]);
      end
   end

   // a read in the cycle of a write returns the old byte
   always_comb begin
      next_rd_data = rd_data;
      if (rd_en_i) begin
         if (access_hit) begin
            if (access_upper) begin
               next_rd_data = high_byte[access_slot];
            end else begin
               next_rd_data = low_byte[access_slot];
            end
         end else begin
            // a miss reads as idle rather than stale data
            next_rd_data = READ_IDLE;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data <= READ_IDLE;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   // effects den4, upper and lower byte
   coeff_pair #(
      .RESET_HIGH (RST_EFFECTS_DEN4_HIGH),
      .RESET_LOW  (RST_EFFECTS_DEN4_LOW)
   ) u_effects_den4 (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .wr_high_i (wr_high[SLOT_EFFECTS_DEN4]),
      .wr_low_i  (wr_low[SLOT_EFFECTS_DEN4]),
      .wr_data_i (wr_data_i),
      .high_o    (high_byte[SLOT_EFFECTS_DEN4]),
      .low_o     (low_byte[SLOT_EFFECTS_DEN4]),
      .coeff_o   (coeff[SLOT_EFFECTS_DEN4])
   );

   // effects den5, upper and lower byte
   coeff_pair #(
      .RESET_HIGH (RST_EFFECTS_DEN5_HIGH),
      .RESET_LOW  (RST_EFFECTS_DEN5_LOW)
   ) u_effects_den5 (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .wr_high_i (wr_high[SLOT_EFFECTS_DEN5]),
      .wr_low_i  (wr_low[SLOT_EFFECTS_DEN5]),
      .wr_data_i (wr_data_i),
      .high_o    (high_byte[SLOT_EFFECTS_DEN5]),
      .low_o     (low_byte[SLOT_EFFECTS_DEN5]),
      .coeff_o   (coeff[SLOT_EFFECTS_DEN5])
   );

   // de-emphasis num0, upper and lower byte
   coeff_pair #(
      .RESET_HIGH (RST_DEEMPH_NUM0_HIGH),
      .RESET_LOW  (RST_DEEMPH_NUM0_LOW)
   ) u_deemph_num0 (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .wr_high_i (wr_high[SLOT_DEEMPH_NUM0]),
      .wr_low_i  (wr_low[SLOT_DEEMPH_NUM0]),
      .wr_data_i (wr_data_i),
      .high_o    (high_byte[SLOT_DEEMPH_NUM0]),
      .low_o     (low_byte[SLOT_DEEMPH_NUM0]),
      .coeff_o   (coeff[SLOT_DEEMPH_NUM0])
   );

   // de-emphasis num1, upper and lower byte
   coeff_pair #(
      .RESET_HIGH (RST_DEEMPH_NUM1_HIGH),
      .RESET_LOW  (RST_DEEMPH_NUM1_LOW)
   ) u_deemph_num1 (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .wr_high_i (wr_high[SLOT_DEEMPH_NUM1]),
      .wr_low_i  (wr_low[SLOT_DEEMPH_NUM1]),
      .wr_data_i (wr_data_i),
      .high_o    (high_byte[SLOT_DEEMPH_NUM1]),
      .low_o     (low_byte[SLOT_DEEMPH_NUM1]),
      .coeff_o   (coeff[SLOT_DEEMPH_NUM1])
   );

   // de-emphasis den1; its lower byte sits one index past the upper
   coeff_pair #(
      .RESET_HIGH (RST_DEEMPH_DEN1_HIGH),
      .RESET_LOW  (RST_DEEMPH_DEN1_LOW)
   ) u_deemph_den1 (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .wr_high_i (wr_high[SLOT_DEEMPH_DEN1]),
      .wr_low_i  (wr_low[SLOT_DEEMPH_DEN1]),
      .wr_data_i (wr_data_i),
      .high_o    (high_byte[SLOT_DEEMPH_DEN1]),
      .low_o     (low_byte[SLOT_DEEMPH_DEN1]),
      .coeff_o   (coeff[SLOT_DEEMPH_DEN1])
   );

   // hit is combinational so a master can qualify its own access
   assign hit_o          = access_hit;
   assign rd_data_o      = rd_data;

   // each access writes a single byte, so both bytes never change in one cycle;
   // the datapath may see a half-updated word between two writes
   assign effects_den4_o = coeff[SLOT_EFFECTS_DEN4];
   assign effects_den5_o = coeff[SLOT_EFFECTS_DEN5];
   assign deemph_num0_o  = coeff[SLOT_DEEMPH_NUM0];
   assign deemph_num1_o  = coeff[SLOT_DEEMPH_NUM1];
   assign deemph_den1_o  = coeff[SLOT_DEEMPH_DEN1];

endmodule // right_filter_coeff_bank

//--- tb/coeff_pair_monitor.sv
// Purpose: checks on the coefficient bank, seen from its ports only
// Assumes: one clock, asynchronous active-low reset
// Notes:   expected values come from the package constants
module coeff_bank_monitor
   import coeff_bank_pkg::*;
(
   input wire logic                      clk_sys_i,
   input wire logic                      arst_n_i,
   input wire logic        [PAGE_W-1:0]  page_i,
   input wire logic        [INDEX_W-1:0] index_i,
   input wire logic                      wr_en_i,
   input wire logic        [BYTE_W-1:0]  wr_data_i,
   input wire logic                      rd_en_i,
   input wire logic                      hit_o,
   input wire logic        [BYTE_W-1:0]  rd_data_o,
   input wire logic signed [COEFF_W-1:0] effects_den4_o,
   input wire logic signed [COEFF_W-1:0] effects_den5_o,
   input wire logic signed [COEFF_W-1:0] deemph_num0_o,
   input wire logic signed [COEFF_W-1:0] deemph_num1_o,
   input wire logic signed [COEFF_W-1:0] deemph_den1_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   AST_RST_DEN4: assert property ($rose(arst_n_i) |->
      effects_den4_o == {RST_EFFECTS_DEN4_HIGH, RST_EFFECTS_DEN4_LOW})
      else $error("den4 reset value wrong");
   AST_RST_DEN5: assert property ($rose(arst_n_i) |->
      effects_den5_o == {RST_EFFECTS_DEN5_HIGH, RST_EFFECTS_DEN5_LOW})
      else $error("den5 reset value wrong");
   AST_RST_NUM0: assert property ($rose(arst_n_i) |->
      deemph_num0_o == {RST_DEEMPH_NUM0_HIGH, RST_DEEMPH_NUM0_LOW})
      else $error("num0 reset value wrong");
   AST_RST_NUM1: assert property ($rose(arst_n_i) |->
      deemph_num1_o == {RST_DEEMPH_NUM1_HIGH, RST_DEEMPH_NUM1_LOW})
      else $error("num1 reset value wrong");
   AST_RST_DEN1_HIGH: assert property ($rose(arst_n_i) |->
      deemph_den1_o[15:8] == RST_DEEMPH_DEN1_HIGH)
      else $error("den1 upper reset value wrong");
   AST_RST_DEN1_LOW: assert property ($rose(arst_n_i) |->
      deemph_den1_o[7:0] == RST_DEEMPH_DEN1_LOW)
      else $error("den1 lower reset value wrong");
   AST_SIGNED: assert property ($rose(arst_n_i) |-> deemph_num1_o < 0)
      else $error("num1 not negative after reset");
   AST_WR_DEN4_HIGH: assert property (
      wr_en_i && page_i == BANK_PAGE && index_i == RIGHT_EFFECTS_DEN4_HIGH
      |=> effects_den4_o[15:8] == $past(wr_data_i))
      else $error("den4 upper write lost");
   AST_WR_DEN1_LOW: assert property (
      wr_en_i && page_i == BANK_PAGE && index_i == RIGHT_DEEMPH_DEN1_LOW
      |=> deemph_den1_o[7:0] == $past(wr_data_i))
      else $error("den1 lower write lost");
   AST_HOLD_DEN5: assert property (!wr_en_i |=> $stable(effects_den5_o))
      else $error("den5 changed without write");
   AST_READ_NUM1_LOW: assert property (
      rd_en_i && page_i == BANK_PAGE && index_i == RIGHT_DEEMPH_NUM1_LOW
      |=> rd_data_o == $past(deemph_num1_o[7:0]))
      else $error("num1 lower readback wrong");
   AST_MISS_READ: assert property (
      rd_en_i && page_i != BANK_PAGE |=> rd_data_o == READ_IDLE)
      else $error("miss read not idle");
   AST_HIT: assert property (hit_o == (page_i == BANK_PAGE
      && index_i >= RIGHT_EFFECTS_DEN4_HIGH && index_i <= RIGHT_DEEMPH_DEN1_LOW))
      else $error("hit decode wrong");

   COV_WRITE: cover property (wr_en_i && hit_o);
   COV_READ: cover property (rd_en_i && hit_o);
   COV_RESET: cover property ($rose(arst_n_i));
endmodule // coeff_bank_monitor

bind right_filter_coeff_bank coeff_bank_monitor mon (.*);

//--- tb/testbench.sv
// Purpose: bench for the right channel coefficient bank
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   rows walk every register; resets and misses are hand-written
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import coeff_bank_pkg::*;

   typedef struct packed {
      logic [6:0]  idx;
      logic [7:0]  data;
      logic [2:0]  slot;
      logic [15:0] word;
   } row_s;

   // each row: index written, byte, slot, whole coefficient expected after it
   localparam row_s ROWS [10] = '{
      '{7'h2B, 8'h80, 3'h0, 16'h8083}, '{7'h2C, 8'h00, 3'h0, 16'h8000},
      '{7'h2D, 8'h7F, 3'h1, 16'h7FEE}, '{7'h2E, 8'hFF, 3'h1, 16'h7FFF},
      '{7'h2F, 8'hFF, 3'h2, 16'hFF55}, '{7'h30, 8'hFF, 3'h2, 16'hFFFF},
      '{7'h31, 8'h00, 3'h3, 16'h002D}, '{7'h32, 8'h00, 3'h3, 16'h0000},
      '{7'h33, 8'hA5, 3'h4, 16'hA57E}, '{7'h34, 8'h5A, 3'h4, 16'hA55A}};

   logic               clk_sys_i;
   logic               arst_n_i;
   logic [7:0]         page;
   logic [6:0]         index;
   logic               wr_en;
   logic [7:0]         wr_data;
   logic               rd_en;
   logic               hit;
   logic [7:0]         rd_data;
   logic signed [15:0] cf [5];
   logic [7:0]         got;
   int                 num_errors = 0;
   int                 cmp_count = 0;

   right_filter_coeff_bank DUT (
      .clk_sys_i      (clk_sys_i),
      .arst_n_i       (arst_n_i),
      .page_i         (page),
      .index_i        (index),
      .wr_en_i        (wr_en),
      .wr_data_i      (wr_data),
      .rd_en_i        (rd_en),
      .hit_o          (hit),
      .rd_data_o      (rd_data),
      .effects_den4_o (cf[0]),
      .effects_den5_o (cf[1]),
      .deemph_num0_o  (cf[2]),
      .deemph_num1_o  (cf[3]),
      .deemph_den1_o  (cf[4])
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // the whole run is well under 200 cycles
   initial begin
      #100us;
      num_errors++;
      finish_test();
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // an idle edge after each access keeps strobes from being set twice in a step
   task automatic write_reg(input logic [7:0] pg, input logic [6:0] idx, input logic [7:0] data);
      page = pg;
      index = idx;
      wr_data = data;
      wr_en = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_en = 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic read_reg(input logic [7:0] pg, input logic [6:0] idx, output logic [7:0] data);
      page = pg;
      index = idx;
      rd_en = 1'b1;
      @(posedge clk_sys_i);
      #1;
      rd_en = 1'b0;
      data = rd_data;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic check_reset();
      check("den4 reset", cf[0], {RST_EFFECTS_DEN4_HIGH, RST_EFFECTS_DEN4_LOW});
      check("den5 reset", cf[1], {RST_EFFECTS_DEN5_HIGH, RST_EFFECTS_DEN5_LOW});
      check("num0 reset", cf[2], {RST_DEEMPH_NUM0_HIGH, RST_DEEMPH_NUM0_LOW});
      check("num1 reset", cf[3], {RST_DEEMPH_NUM1_HIGH, RST_DEEMPH_NUM1_LOW});
      check("den1 reset", cf[4], {RST_DEEMPH_DEN1_HIGH, RST_DEEMPH_DEN1_LOW});
      check("read idle", rd_data, READ_IDLE);
   endtask

   initial begin
      arst_n_i = 1'b0;
      page = 8'h00;
      index = 7'h00;
      wr_en = 1'b0;
      wr_data = 8'h00;
      rd_en = 1'b0;
      repeat (6) @(posedge clk_sys_i);
      #1;
      arst_n_i = 1'b1;
      check_reset();
      for (int r = 0; r < 10; r++) begin
         write_reg(BANK_PAGE, ROWS[r].idx, ROWS[r].data);
         check("hit", hit, 16'h0001);
         check("coeff", cf[ROWS[r].slot], ROWS[r].word);
         read_reg(BANK_PAGE, ROWS[r].idx, got);
         check("read", got, ROWS[r].data);
      end
      // accesses outside the bank leave it alone
      write_reg(8'h00, 7'h2B, 8'h11);
      check("other page write", cf[0], 16'h8000);
      write_reg(BANK_PAGE, 7'h35, 8'h22);
      check("outside hit", hit, 16'h0000);
      check("outside write", cf[4], 16'hA55A);
      read_reg(8'h00, 7'h34, got);
      check("miss read", got, READ_IDLE);
      // mid-run reset over written values
      arst_n_i = 1'b0;
      repeat (6) @(posedge clk_sys_i);
      #1;
      arst_n_i = 1'b1;
      check_reset();
      read_reg(BANK_PAGE, 7'h33, got);
      check("den1 upper read", got, RST_DEEMPH_DEN1_HIGH);
      read_reg(BANK_PAGE, 7'h34, got);
      check("den1 lower read", got, RST_DEEMPH_DEN1_LOW);
      finish_test();
   end
endmodule // testbench
